// [pcfg_powerup_init.v]
`timescale 1ns/1ps
`include "pcfg_defines.vh"

module pcfg_powerup_init #(
  parameter ADC_W        = 10,
  parameter VIN_W        = 8,
  parameter CYCLES_PER_MS = `PCFG_MS_NS / `PCFG_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             nrst,
  // Supply monitors and oscillator
  input  wire             vccGood,
  input  wire             coreSupplyRailGood,
  input  wire             oscStable,
  // Analog comparators and bus voltage level
  input  wire             enableForcedModePinAbove,
  input  wire [VIN_W-1:0] vinLevel,
  // Strap converter
  output reg              adcStart_q,
  input  wire             adcDone,
  input  wire [ADC_W-1:0] adcData,
  // Command port from the bus front end
  input  wire             cmdValid,
  input  wire             cmdIsPmbus,
  input  wire [6:0]       cmdAddr,
  input  wire             cmdWrite,
  input  wire [2:0]       cmdReg,
  input  wire [7:0]       cmdWdata,
  output reg              cmdAck_q,
  output reg  [7:0]       cmdRdata_q,
  // Status and control outputs
  output reg              porActive_q,
  output reg              configLoaded_q,
  output reg              addrRead_q,
  output reg              analogMode_q,
  output reg              commPinsAnalog_q,
  output reg              undervoltageLockoutClear_q,
  output reg              powerEnable_q,
  output reg              rampStart_q,
  output reg  [6:0]       i2cAddr_q,
  output reg  [6:0]       pmbusAddr_q
);

  localparam [3:0] ST_RESET = 4'h1;
  localparam [3:0] ST_LOAD  = 4'h2;
  localparam [3:0] ST_ADDR  = 4'h4;
  localparam [3:0] ST_READY = 4'h8;

  reg  [3:0]  state_q;
  reg  [2:0]  loadIdx_q;
  reg         loadCapture_q;
  reg         adcWait_q;
  reg  [3:0]  offset_q;
  reg  [7:0]  i2cBase_q;
  reg  [7:0]  pmbusBase_q;
  reg  [7:0]  onCtrl_q;
  reg  [7:0]  vinOn_q;
  reg  [7:0]  vinOff_q;
  reg  [7:0]  tonDelay_q;
  reg  [6:0]  msLeft_q;
  reg  [31:0] tickCnt_q;
  reg         delayRun_q;
  wire [7:0]  nvmData;
  wire        suppliesGood;
  wire [15:0] aboveStep;
  reg  [3:0]  strapOffset;
  reg         startCond;
  reg         hit;
  reg  [7:0]  rdWord;
  integer     k;

  pcfg_config_nvm #(
    .WIDTH (8),
    .AW    (3)
  ) uNvm (
    .mclk     (mclk),
    .nrst     (nrst),
    .rdAddr   (loadIdx_q),
    .rdData_q (nvmData)
  );

  assign suppliesGood = vccGood & coreSupplyRailGood & oscStable;

  // Sixteen strap bins, 60 codes wide except the open top bin
  assign aboveStep[0] = 1'b0;
  genvar g;
  generate
    for (g = 1; g < 16; g = g + 1)
    begin : gStrap
      assign aboveStep[g] =
        (adcData >= g * `PCFG_STRAP_STEP);
    end
  endgenerate

  always @*
  begin
    strapOffset = 4'h0;
    for (k = 1; k < 16; k = k + 1)
      if (aboveStep[k])
        strapOffset = k[3:0];
  end

  // Initialization sequencer
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q        <= ST_RESET;
      porActive_q    <= 1'b1;
      loadIdx_q      <= 3'h0;
      loadCapture_q  <= 1'b0;
      configLoaded_q <= 1'b0;
      adcStart_q     <= 1'b0;
      adcWait_q      <= 1'b0;
      addrRead_q     <= 1'b0;
      offset_q       <= 4'h0;
      analogMode_q   <= 1'b0;
      commPinsAnalog_q <= 1'b0;
    end
    else
    begin
      adcStart_q <= 1'b0;
      if (!suppliesGood)
      begin
        // Supply loss drops state and load/address flags back to power-on reset; offset and mode hold
        state_q        <= ST_RESET;
        porActive_q    <= 1'b1;
        configLoaded_q <= 1'b0;
        addrRead_q     <= 1'b0;
        adcWait_q      <= 1'b0;
        loadCapture_q  <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_RESET:
          begin
            porActive_q   <= 1'b0;
            loadIdx_q     <= 3'h0;
            loadCapture_q <= 1'b0;
            state_q       <= ST_LOAD;
          end
          ST_LOAD:
          begin
            // Memory read is registered: capture runs one word behind
            loadCapture_q <= 1'b1;
            if (loadCapture_q && loadIdx_q == `PCFG_IDX_LAST + 3'h1)
            begin
              configLoaded_q <= 1'b1;
              adcStart_q     <= 1'b1;
              adcWait_q      <= 1'b1;
              state_q        <= ST_ADDR;
            end
            else
              loadIdx_q <= loadIdx_q + 3'h1;
          end
          ST_ADDR:
          begin
            if (adcWait_q && adcDone)
            begin
              adcWait_q  <= 1'b0;
              addrRead_q <= 1'b1;
              offset_q   <= strapOffset;
              // Full-scale reading means nothing pulls the strap down
              analogMode_q     <= (adcData >= `PCFG_STRAP_FLOAT);
              commPinsAnalog_q <= (adcData >= `PCFG_STRAP_FLOAT);
              state_q    <= ST_READY;
            end
          end
          ST_READY:
            state_q <= ST_READY;
          default:
            state_q <= ST_RESET;
        endcase
      end
    end
  end

  // Command decode: only in digital mode once loaded and addressed
  always @*
  begin
    hit = 1'b0;
    if (state_q == ST_READY && !analogMode_q && cmdValid)
    begin
      if (cmdIsPmbus)
        hit = (pmbusBase_q[6:0] != 7'h00) &&
              (cmdAddr == pmbusAddr_q);
      else
        hit = (i2cBase_q[6:0] != 7'h00) &&
              (cmdAddr == i2cAddr_q);
    end
  end

  always @*
  begin
    case (cmdReg)
      `PCFG_IDX_I2C_BASE:   rdWord = i2cBase_q;
      `PCFG_IDX_PMBUS_BASE: rdWord = pmbusBase_q;
      `PCFG_IDX_ON_CTRL:    rdWord = onCtrl_q;
      `PCFG_IDX_VIN_ON:     rdWord = vinOn_q;
      `PCFG_IDX_VIN_OFF:    rdWord = vinOff_q;
      `PCFG_IDX_TON_DELAY:  rdWord = tonDelay_q;
      default:              rdWord = 8'h00;
    endcase
  end

  // Working registers: filled by the load, then by the host
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      i2cBase_q   <= 8'h00;
      pmbusBase_q <= 8'h00;
      onCtrl_q    <= 8'h00;
      vinOn_q     <= 8'h00;
      vinOff_q    <= 8'h00;
      tonDelay_q  <= 8'h00;
      cmdAck_q    <= 1'b0;
      cmdRdata_q  <= 8'h00;
    end
    else
    begin
      cmdAck_q <= hit;
      if (hit && !cmdWrite)
        cmdRdata_q <= rdWord;
      if (state_q == ST_LOAD && loadCapture_q)
      begin
        case (loadIdx_q - 3'h1)
          `PCFG_IDX_I2C_BASE:   i2cBase_q   <= nvmData;
          `PCFG_IDX_PMBUS_BASE: pmbusBase_q <= nvmData;
          `PCFG_IDX_ON_CTRL:    onCtrl_q    <= nvmData;
          `PCFG_IDX_VIN_ON:     vinOn_q     <= nvmData;
          `PCFG_IDX_VIN_OFF:    vinOff_q    <= nvmData;
          `PCFG_IDX_TON_DELAY:  tonDelay_q  <= nvmData;
          default:              tonDelay_q  <= tonDelay_q;
        endcase
      end
      else if (hit && cmdWrite)
      begin
        case (cmdReg)
          `PCFG_IDX_I2C_BASE:   i2cBase_q   <= {1'b0, cmdWdata[6:0]};
          `PCFG_IDX_PMBUS_BASE: pmbusBase_q <= {1'b0, cmdWdata[6:0]};
          `PCFG_IDX_ON_CTRL:    onCtrl_q    <= cmdWdata;
          `PCFG_IDX_VIN_ON:     vinOn_q     <= cmdWdata;
          `PCFG_IDX_VIN_OFF:    vinOff_q    <= cmdWdata;
          `PCFG_IDX_TON_DELAY:  tonDelay_q  <= {1'b0, cmdWdata[6:0]};
          default:              tonDelay_q  <= tonDelay_q;
        endcase
      end
    end
  end

  // Effective addresses; a wrap past 0x7f is the user's problem
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      i2cAddr_q   <= 7'h00;
      pmbusAddr_q <= 7'h00;
    end
    else
    begin
      i2cAddr_q   <= i2cBase_q[6:0] + {3'h0, offset_q};
      pmbusAddr_q <= pmbusBase_q[6:0] + {3'h0, offset_q};
    end
  end

  // Bus voltage lockout with on/off hysteresis
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      undervoltageLockoutClear_q <= 1'b0;
    else if (!configLoaded_q)
      undervoltageLockoutClear_q <= 1'b0;
    else if (!undervoltageLockoutClear_q && vinLevel >= vinOn_q)
      undervoltageLockoutClear_q <= 1'b1;
    else if (undervoltageLockoutClear_q && vinLevel < vinOff_q)
      undervoltageLockoutClear_q <= 1'b0;
  end

  always @*
  begin
    if (!analogMode_q && onCtrl_q[`PCFG_ON_SW_SELECT])
      startCond = onCtrl_q[`PCFG_ON_SW_RUN];
    else
      startCond = enableForcedModePinAbove &&
                  undervoltageLockoutClear_q;
  end

  // Conversion enable and delayed ramp start
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      powerEnable_q <= 1'b0;
      rampStart_q   <= 1'b0;
      delayRun_q    <= 1'b0;
      msLeft_q      <= 7'h00;
      tickCnt_q     <= 32'h0;
    end
    else
    begin
      // Supply loss must drop conversion at the same edge as the load flag
      powerEnable_q <= suppliesGood && startCond && configLoaded_q &&
                       addrRead_q && state_q == ST_READY;
      if (!powerEnable_q)
      begin
        rampStart_q <= 1'b0;
        delayRun_q  <= 1'b0;
        tickCnt_q   <= 32'h0;
        // Analog mode has no delay setting; it starts at once
        msLeft_q    <= analogMode_q ? 7'h00 : tonDelay_q[6:0];
      end
      else if (!rampStart_q)
      begin
        delayRun_q <= 1'b1;
        if (msLeft_q == 7'h00)
          rampStart_q <= 1'b1;
        else if (tickCnt_q == CYCLES_PER_MS - 1)
        begin
          tickCnt_q <= 32'h0;
          msLeft_q  <= msLeft_q - 7'h01;
        end
        else
          tickCnt_q <= tickCnt_q + 32'h1;
      end
    end
  end

endmodule

// [pcfg_defines.vh]
`ifndef PCFG_DEFINES_VH
`define PCFG_DEFINES_VH

// Working register indices (word addresses of the command port)
`define PCFG_IDX_I2C_BASE    3'h0
`define PCFG_IDX_PMBUS_BASE  3'h1
`define PCFG_IDX_ON_CTRL     3'h2
`define PCFG_IDX_VIN_ON      3'h3
`define PCFG_IDX_VIN_OFF     3'h4
`define PCFG_IDX_TON_DELAY   3'h5
`define PCFG_IDX_LAST        3'h5

// Stored default contents of config_nvm
`define PCFG_DEF_I2C_BASE    8'h10
`define PCFG_DEF_PMBUS_BASE  8'h40
`define PCFG_DEF_ON_CTRL     8'h00
`define PCFG_DEF_VIN_ON      8'h04
`define PCFG_DEF_VIN_OFF     8'h04
`define PCFG_DEF_TON_DELAY   8'h00

// Fields of the on-control register
`define PCFG_ON_SW_SELECT    0
`define PCFG_ON_SW_RUN       1

// Base address field and delay field widths
`define PCFG_BASE_MSB        6
`define PCFG_DELAY_MSB       6

// Strap converter decoding
`define PCFG_STRAP_STEP      60
`define PCFG_STRAP_FLOAT     10'h3c0

// Timing
`define PCFG_CLK_PERIOD_NS   100
`define PCFG_MS_NS           1000000

`endif

// [pcfg_config_nvm.v]
`timescale 1ns/1ps
`include "pcfg_defines.vh"

module pcfg_config_nvm #(
  parameter WIDTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             nrst,
  // Read port
  input  wire [AW-1:0]    rdAddr,
  output reg  [WIDTH-1:0] rdData_q
);

  reg [WIDTH-1:0] word;

  // Fixed contents; programming path lives outside this block
  always @*
  begin
    case (rdAddr)
      `PCFG_IDX_I2C_BASE:   word = `PCFG_DEF_I2C_BASE;
      `PCFG_IDX_PMBUS_BASE: word = `PCFG_DEF_PMBUS_BASE;
      `PCFG_IDX_ON_CTRL:    word = `PCFG_DEF_ON_CTRL;
      `PCFG_IDX_VIN_ON:     word = `PCFG_DEF_VIN_ON;
      `PCFG_IDX_VIN_OFF:    word = `PCFG_DEF_VIN_OFF;
      `PCFG_IDX_TON_DELAY:  word = `PCFG_DEF_TON_DELAY;
      default:              word = {WIDTH{1'b0}};
    endcase
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rdData_q <= {WIDTH{1'b0}};
    else
      rdData_q <= word;
  end

endmodule

// [pcfg_host_model.sv]
`timescale 1ns/1ps
module pcfg_host_model (
  // Clock
  input  wire       mclk,
  // Strap converter
  input  wire       adcStart,
  input  wire [9:0] strapCode,
  output reg        adcDone,
  output reg  [9:0] adcData,
  // Command port
  output reg        cmdValid,
  output reg        cmdIsPmbus,
  output reg  [6:0] cmdAddr,
  output reg        cmdWrite,
  output reg  [2:0] cmdReg,
  output reg  [7:0] cmdWdata,
  input  wire       cmdAck,
  input  wire [7:0] cmdRdata
);
  reg [2:0] pend;
  initial
  begin
    {cmdValid, cmdIsPmbus, cmdAddr, cmdWrite, cmdReg, cmdWdata} = 0;
    pend = 3'h0;
    adcDone = 1'b0;
    adcData = 10'h155;
  end
  // Slow converter; data toggles outside the valid cycle
  always @(posedge mclk)
  begin
    pend <= {pend[1:0], adcStart};
    adcDone <= pend[2];
    adcData <= pend[2] ? strapCode : ~adcData;
  end
  // One request, held one edge, answer taken the cycle after
  task xfer(input p, input [6:0] a, input w, input [2:0] r,
            input [7:0] d, output ack, output [7:0] rd);
  begin
    @(posedge mclk);
    {cmdValid, cmdIsPmbus, cmdAddr, cmdWrite, cmdReg, cmdWdata}
      <= {1'b1, p, a, w, r, d};
    @(posedge mclk);
    cmdValid <= 1'b0;
    cmdWdata <= ~d;
    @(negedge mclk);
    ack = cmdAck;
    rd = cmdRdata;
  end
  endtask
endmodule

// [pcfg_powerup_init_sva.sv]
`timescale 1ns/1ps
module pcfg_powerup_init_sva (
  // Clock, reset, supplies, enable pin
  input wire       mclk,
  input wire       nrst,
  input wire       vccGood,
  input wire       coreSupplyRailGood,
  input wire       oscStable,
  input wire       enableForcedModePinAbove,
  // Command and strap
  input wire       adcStart_q,
  input wire       cmdValid,
  input wire       cmdAck_q,
  // Status
  input wire       porActive_q,
  input wire       configLoaded_q,
  input wire       addrRead_q,
  input wire       analogMode_q,
  input wire       commPinsAnalog_q,
  input wire       undervoltageLockoutClear_q,
  input wire       powerEnable_q,
  input wire       rampStart_q,
  input wire [6:0] i2cAddr_q,
  input wire [6:0] pmbusAddr_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_loadDone;
    $rose(configLoaded_q);
  endsequence
  sequence s_strapTaken;
    $rose(addrRead_q) ##1 1'b1;
  endsequence
  a_supply_hold: assert property (!(vccGood && coreSupplyRailGood &&
    oscStable) |=> !configLoaded_q && !powerEnable_q)
    else $error("load or power while supplies bad");
  a_load_time: assert property ($fell(porActive_q) |->
    ##[1:12] configLoaded_q) else $error("load not finished in time");
  a_init_order: assert property (s_loadDone |-> !addrRead_q[*2])
    else $error("address read before load");
  a_strap_once: assert property (addrRead_q |-> !adcStart_q)
    else $error("strap sampled after init");
  a_addr_form: assert property (s_strapTaken |->
    (i2cAddr_q - 7'h10) <= 7'h0f && pmbusAddr_q == i2cAddr_q + 7'h30)
    else $error("address not base plus offset");
  a_ack_cause: assert property (cmdAck_q |-> $past(cmdValid) &&
    addrRead_q && !analogMode_q) else $error("ack without valid request");
  a_power_gate: assert property (powerEnable_q |->
    $past(configLoaded_q && addrRead_q)) else $error("power before ready");
  a_analog_start: assert property (analogMode_q && $rose(powerEnable_q) |->
    $past(enableForcedModePinAbove && undervoltageLockoutClear_q))
    else $error("analog start without pin and lockout");
  a_pins_follow: assert property (commPinsAnalog_q == analogMode_q)
    else $error("pins not following mode");
  a_ramp_after: assert property ($rose(rampStart_q) |-> $past(powerEnable_q))
    else $error("ramp without power");
endmodule

// [tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    samplesChecked++; \
    if ((g) !== (e)) \
    begin \
      nMismatch++; \
      $display("mismatch %s exp %h got %h", n, e, g); \
    end \
  end
module tb;
  reg        mclk, nrst, supOk, pin;
  reg  [7:0] vin;
  reg  [9:0] strap;
  wire       adcStart, adcDone, cmdValid, cmdIsPmbus, cmdWrite, cmdAck;
  wire       cfgLoaded, addrRead, analog, pinsAnalog, uvClear, powerEn, ramp;
  wire       por;
  wire [9:0] adcData;
  wire [6:0] cmdAddr, i2cAddr, pmbusAddr;
  wire [2:0] cmdReg;
  wire [7:0] cmdWdata, cmdRdata;
  reg  [7:0] defs [0:5];
  integer    nMismatch, samplesChecked, cyc, i;
  reg        ack;
  reg  [7:0] rd;
  pcfg_host_model host_i (.mclk(mclk), .adcStart(adcStart), .strapCode(strap),
    .adcDone(adcDone), .adcData(adcData), .cmdValid(cmdValid),
    .cmdIsPmbus(cmdIsPmbus), .cmdAddr(cmdAddr), .cmdWrite(cmdWrite),
    .cmdReg(cmdReg), .cmdWdata(cmdWdata), .cmdAck(cmdAck), .cmdRdata(cmdRdata));
  pcfg_powerup_init #(.CYCLES_PER_MS(4)) pcfg_powerup_init_i (.mclk(mclk),
    .nrst(nrst), .vccGood(supOk), .coreSupplyRailGood(supOk),
    .oscStable(supOk), .enableForcedModePinAbove(pin), .vinLevel(vin),
    .adcStart_q(adcStart), .adcDone(adcDone), .adcData(adcData),
    .cmdValid(cmdValid), .cmdIsPmbus(cmdIsPmbus), .cmdAddr(cmdAddr),
    .cmdWrite(cmdWrite), .cmdReg(cmdReg), .cmdWdata(cmdWdata),
    .cmdAck_q(cmdAck), .cmdRdata_q(cmdRdata), .porActive_q(por),
    .configLoaded_q(cfgLoaded), .addrRead_q(addrRead), .analogMode_q(analog),
    .commPinsAnalog_q(pinsAnalog), .undervoltageLockoutClear_q(uvClear),
    .powerEnable_q(powerEn), .rampStart_q(ramp), .i2cAddr_q(i2cAddr),
    .pmbusAddr_q(pmbusAddr));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task final_report;
  begin
    if (nMismatch == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task boot(input [9:0] s);
  begin
    strap = s;
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (40) if (addrRead !== 1'b1) @(posedge mclk);
    repeat (3) @(posedge mclk);
  end
  endtask
  task cmd(input p, input [6:0] a, input w, input [2:0] r, input [7:0] d,
           input ea, input [7:0] er);
  begin
    host_i.xfer(p, a, w, r, d, ack, rd);
    `CHK("ack", ea, ack)
    if (ea && !w)
      `CHK("rdata", er, rd)
  end
  endtask
  task settle(input [7:0] v, input pn);
  begin
    vin <= v;
    pin <= pn;
    repeat (3) @(posedge mclk);
  end
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      nMismatch++;
      final_report;
    end
  end
  initial
  begin
    {nMismatch, samplesChecked, cyc} = 0;
    {nrst, pin, vin, strap} = 0;
    supOk = 1'b1;
    {defs[0], defs[1], defs[2], defs[3], defs[4], defs[5]} = 48'h104000040400;
    boot(10'd200);
    `CHK("i2cAddr", 7'h13, i2cAddr)
    `CHK("pmbusAddr", 7'h43, pmbusAddr)
    for (i = 0; i < 6; i++)
      cmd(1'b0, 7'h13, 1'b0, i[2:0], 8'h00, 1'b1, defs[i]);
    cmd(1'b1, 7'h43, 1'b0, 3'h7, 8'h00, 1'b1, 8'h00);
    cmd(1'b0, 7'h14, 1'b0, 3'h0, 8'h00, 1'b0, 8'h00);
    cmd(1'b0, 7'h13, 1'b1, 3'h0, 8'h00, 1'b1, 8'h00);
    cmd(1'b0, 7'h03, 1'b0, 3'h0, 8'h00, 1'b0, 8'h00);
    cmd(1'b1, 7'h43, 1'b1, 3'h0, 8'h20, 1'b1, 8'h00);
    repeat (2) @(posedge mclk);
    `CHK("i2cAddr", 7'h23, i2cAddr)
    cmd(1'b1, 7'h43, 1'b1, 3'h3, 8'h08, 1'b1, 8'h00);
    settle(8'h06, 1'b0);
    `CHK("uvClear", 1'b0, uvClear)
    settle(8'h08, 1'b0);
    `CHK("uvClear", 1'b1, uvClear)
    `CHK("powerEn", 1'b0, powerEn)
    settle(8'h08, 1'b1);
    `CHK("powerEn", 1'b1, powerEn)
    `CHK("ramp", 1'b1, ramp)
    cmd(1'b1, 7'h43, 1'b1, 3'h2, 8'h01, 1'b1, 8'h00);
    settle(8'h08, 1'b1);
    `CHK("powerEn", 1'b0, powerEn)
    cmd(1'b1, 7'h43, 1'b1, 3'h5, 8'h02, 1'b1, 8'h00);
    cmd(1'b1, 7'h43, 1'b1, 3'h2, 8'h03, 1'b1, 8'h00);
    repeat (4) if (powerEn !== 1'b1) @(negedge mclk);
    repeat (4) @(negedge mclk);
    `CHK("ramp", 1'b0, ramp)
    repeat (8) @(negedge mclk);
    `CHK("ramp", 1'b1, ramp)
    @(posedge mclk);
    supOk <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("cfgLoaded", 1'b0, cfgLoaded)
    `CHK("por", 1'b1, por)
    `CHK("powerEn", 1'b0, powerEn)
    supOk <= 1'b1;
    boot(10'h3c0);
    `CHK("analog", 1'b1, analog)
    `CHK("pinsAnalog", 1'b1, pinsAnalog)
    cmd(1'b0, 7'h10, 1'b0, 3'h0, 8'h00, 1'b0, 8'h00);
    cmd(1'b1, 7'h4f, 1'b1, 3'h2, 8'h03, 1'b0, 8'h00);
    settle(8'h08, 1'b1);
    `CHK("powerEn", 1'b1, powerEn)
    settle(8'h08, 1'b0);
    `CHK("powerEn", 1'b0, powerEn)
    final_report;
  end
endmodule
bind pcfg_powerup_init pcfg_powerup_init_sva chk_i (.mclk(mclk),
  .nrst(nrst), .vccGood(vccGood), .coreSupplyRailGood(coreSupplyRailGood),
  .oscStable(oscStable), .enableForcedModePinAbove(enableForcedModePinAbove),
  .adcStart_q(adcStart_q), .cmdValid(cmdValid), .cmdAck_q(cmdAck_q),
  .porActive_q(porActive_q), .configLoaded_q(configLoaded_q),
  .addrRead_q(addrRead_q), .analogMode_q(analogMode_q),
  .commPinsAnalog_q(commPinsAnalog_q), .powerEnable_q(powerEnable_q),
  .undervoltageLockoutClear_q(undervoltageLockoutClear_q),
  .rampStart_q(rampStart_q), .i2cAddr_q(i2cAddr_q), .pmbusAddr_q(pmbusAddr_q));
